/* File: common/frs_pkg.sv */
// shared constants and types for the floppy rate and status register block
package frs_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] FRS_MAIN_STATUS_OFF  = 3'h4;
  localparam logic [2:0] FRS_RATE_SELECT_OFF  = 3'h4;
  localparam logic [2:0] FRS_CMD_DATA_OFF     = 3'h5;
  localparam logic [2:0] FRS_DIAG_INPUT_OFF   = 3'h7;
  localparam logic [2:0] FRS_CONFIG_CTRL_OFF  = 3'h7;
  localparam logic [2:0] FRS_INT_STATUS_OFF   = 3'h1;
  localparam logic [2:0] FRS_INT_MASK_OFF     = 3'h2;
  localparam logic [2:0] FRS_RESULT_LOAD_OFF  = 3'h3;
  localparam logic [2:0] FRS_FIFO_CTRL_OFF    = 3'h6;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FRS_SWRST_BIT   = 7;
  localparam int FRS_PWRDN_BIT   = 6;
  localparam int FRS_PRECOMP_LSB = 2;
  localparam int FRS_NO_PRECOMP_FLAG_BIT  = 2;
  localparam int FRS_TERM_LSB    = 6;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FRS_RATE_SELECT_RST = 8'h00;
  localparam logic [7:0] FRS_CONFIG_CTRL_RST = 8'h00;
  localparam logic [3:0] FRS_INT_MASK_RST    = 4'h0;
  // ---------------------------------------------------------------
  // rate codes, termination codes, precomp codes
  // ---------------------------------------------------------------
  localparam logic [1:0] FRS_RATE_500K = 2'h0;
  localparam logic [1:0] FRS_RATE_300K = 2'h1;
  localparam logic [1:0] FRS_RATE_250K = 2'h2;
  localparam logic [1:0] FRS_RATE_1M   = 2'h3;
  localparam logic [1:0] FRS_TERM_ABNORMAL = 2'h1;
  localparam logic [1:0] FRS_TERM_INVALID  = 2'h2;
  localparam logic [1:0] FRS_TERM_READY    = 2'h3;
  localparam logic [2:0] FRS_PRECOMP_DEFAULT = 3'h0;
  localparam logic [2:0] FRS_PRECOMP_OFF     = 3'h7;
  // precomp delays in picoseconds as printed
  localparam int FRS_DLY_DEF_LOW_PS = 125000;
  localparam int FRS_DLY_DEF_1M_PS  = 41670;
  localparam int FRS_DLY_DEF_2M_PS  = 20800;
  localparam int FRS_DLY_STEP_PS    = 41670;
  localparam int FRS_DLY_STEP2M_PS  = 20830;
  localparam int FRS_SOFT_RESET_CYCLES = 1;
  // interrupt status bits
  localparam int FRS_EV_SWRST  = 0;
  localparam int FRS_EV_RATE   = 1;
  localparam int FRS_EV_RESULT = 2;
  localparam int FRS_EV_PWRDN  = 3;

  typedef enum logic [1:0] {FRS_MODE_AT, FRS_MODE_STD, FRS_MODE_M30} frs_mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } frs_bus_req_t;

  typedef struct packed {
    logic [1:0] rate_code;
    logic [2:0] precomp_delay_sel;
    logic       reduced_write_current;
    logic       fm_illegal;
    logic       power_down;
    logic       soft_reset;
  } frs_ctrl_t;
endpackage : frs_pkg

/* File: core/frs_regs.sv */
// host register bank: rate select, config control, command/data port, diag input
`timescale 1ns/100ps
`default_nettype none
module frs_regs
  import frs_pkg::*;
#(
  parameter int CLK_PERIOD_PS = 100000
) (
  input  wire logic             clk_i,            // controller clock, 10 MHz
  input  wire logic             rst_b_i,          // master reset, sync, active low
  input  wire frs_pkg::frs_bus_req_t bus_i,       // register bus request
  output logic [7:0]            rdata_o,          // read data, cycle after read
  output logic [7:0]            rdata_oe_o,       // per-bit drive enable of read data
  input  wire frs_pkg::frs_mode_t mode_i,         // interface mode select
  input  wire logic             disk_change_in_i, // drive disk-change pin
  input  wire logic             dma_enable_i,     // digital-output dma enable bit
  input  wire logic [7:0]       main_status_i,    // main status from command engine
  input  wire logic [1:0]       tape_rate_i,      // configuration tape rate bits
  input  wire logic             res_push_i,       // result byte push strobe
  input  wire logic [7:0]       res_data_i,       // result byte
  input  wire logic [1:0]       res_term_i,       // termination code for result 0
  input  wire logic             cfg_cmd_i,        // configure command strobe
  input  wire logic             cfg_fifo_en_i,    // configure: fifo enable
  input  wire logic [3:0]       cfg_thresh_i,     // configure: fifo threshold
  output logic                  cmd_wr_o,         // byte written to data port
  output logic [7:0]            cmd_data_o,       // that byte
  output frs_pkg::frs_ctrl_t    ctrl_o,           // effective rate/precomp controls
  output logic                  tape_2m_o,        // 2 Mb/s tape rate in force
  output logic [15:0]           precomp_ps_o,     // precomp delay, picoseconds, low 16 bits only
  output logic                  fifo_en_o,        // fifo enabled by configure
  output logic [3:0]            fifo_thresh_o,    // fifo threshold
  output logic                  irq_o             // level interrupt
);
  import frs_pkg::*;

  // refuse a clock period that is not positive, at elaboration
  if (CLK_PERIOD_PS <= 0) begin : g_bad_period
    $error("clock period must be positive");
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire wr_rate   = bus_i.wr && (bus_i.addr == FRS_RATE_SELECT_OFF);
  wire wr_cfg    = bus_i.wr && (bus_i.addr == FRS_CONFIG_CTRL_OFF);
  wire wr_data   = bus_i.wr && (bus_i.addr == FRS_CMD_DATA_OFF);
  wire wr_istat  = bus_i.wr && (bus_i.addr == FRS_INT_STATUS_OFF);
  wire wr_imask  = bus_i.wr && (bus_i.addr == FRS_INT_MASK_OFF);
  wire rd_data   = bus_i.rd && (bus_i.addr == FRS_CMD_DATA_OFF);

  // ---------------------------------------------------------------
  // rate select and config control storage
  // ---------------------------------------------------------------
  logic [7:0] rate_sel_reg;
  logic [7:0] rate_sel_next;
  logic [1:0] rate_code_reg;
  logic [1:0] rate_code_next;
  logic       no_precomp_flag_reg;
  logic       no_precomp_flag_next;
  logic       swrst_reg;

  // the software reset bit is self clearing so that one write gives one pulse
  assign rate_sel_next  = wr_rate ? {1'b0, bus_i.wdata[6:0]} : rate_sel_reg;
  // whichever register was written last owns the effective rate
  assign rate_code_next = wr_rate ? bus_i.wdata[1:0] :
                          wr_cfg  ? bus_i.wdata[1:0] : rate_code_reg;
  // bit 2 is kept here and bits 1:0 go to the rate code; upper bits are reserved and dropped
  assign no_precomp_flag_next    = wr_cfg ? bus_i.wdata[FRS_NO_PRECOMP_FLAG_BIT] : no_precomp_flag_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rate_sel_reg  <= FRS_RATE_SELECT_RST;
      rate_code_reg <= FRS_RATE_SELECT_RST[1:0];
      no_precomp_flag_reg    <= FRS_CONFIG_CTRL_RST[FRS_NO_PRECOMP_FLAG_BIT];
      swrst_reg     <= 1'b0;
    end else begin
      rate_sel_reg  <= rate_sel_next;
      rate_code_reg <= rate_code_next;
      no_precomp_flag_reg    <= no_precomp_flag_next;
      swrst_reg     <= wr_rate && bus_i.wdata[FRS_SWRST_BIT];
    end
  end

  // internal reset of the controller logic: master or software
  wire ctl_rst = !rst_b_i || swrst_reg;

  // ---------------------------------------------------------------
  // rate decode and precompensation
  // ---------------------------------------------------------------
  wire [2:0] precomp_sel = rate_sel_reg[FRS_PRECOMP_LSB +: 3];
  wire       rwc_high    = (rate_code_reg == FRS_RATE_500K) ||
                           (rate_code_reg == FRS_RATE_1M);
  wire       tape_2m     = (rate_code_reg == FRS_RATE_300K) && (tape_rate_i == 2'h2);

  logic [16:0] precomp_ps;
  always_comb begin
    precomp_ps = 17'h0;
    if (precomp_sel == FRS_PRECOMP_OFF) begin
      precomp_ps = 17'h0;
    end else if (precomp_sel == FRS_PRECOMP_DEFAULT) begin
      if (tape_2m)                             precomp_ps = 17'(FRS_DLY_DEF_2M_PS);
      else if (rate_code_reg == FRS_RATE_1M)   precomp_ps = 17'(FRS_DLY_DEF_1M_PS);
      else                                     precomp_ps = 17'(FRS_DLY_DEF_LOW_PS);
    end else if (tape_2m) begin
      precomp_ps = 17'(FRS_DLY_STEP2M_PS * int'(precomp_sel));
    end else begin
      precomp_ps = 17'(FRS_DLY_STEP_PS * int'(precomp_sel));
    end
  end

  // ---------------------------------------------------------------
  // result stack (four bytes) and fifo configuration
  // ---------------------------------------------------------------
  logic [7:0] res_mem [4];
  logic [2:0] res_cnt_reg;
  logic [1:0] res_rd_reg;
  logic       fifo_en_reg;
  logic [3:0] fifo_thr_reg;

  wire [7:0] res_byte = (res_cnt_reg == 3'h0) ?
                        {res_term_i, res_data_i[5:0]} : res_data_i;
  wire       res_full = (res_cnt_reg == 3'h4);
  wire       res_avail = (res_cnt_reg != 3'h0);
  wire       res_pop  = rd_data && res_avail;

  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      res_cnt_reg  <= 3'h0;
      res_rd_reg   <= 2'h0;
      fifo_en_reg  <= 1'b0;
      fifo_thr_reg <= 4'h0;
    end else begin
      if (cfg_cmd_i) begin
        fifo_en_reg  <= cfg_fifo_en_i;
        fifo_thr_reg <= cfg_thresh_i;
      end
      if (res_push_i && !res_full) begin
        res_mem[res_cnt_reg[1:0]] <= res_byte;
        res_cnt_reg <= res_cnt_reg + 3'h1;
      end else if (res_pop) begin
        res_rd_reg <= res_rd_reg + 2'h1;
        if (res_rd_reg == 2'(res_cnt_reg - 3'h1)) begin
          res_cnt_reg <= 3'h0;
          res_rd_reg  <= 2'h0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // diagnostic input views
  // ---------------------------------------------------------------
  wire low_dens = (rate_code_reg == FRS_RATE_300K) || (rate_code_reg == FRS_RATE_250K);
  wire [7:0] diag_std = {~disk_change_in_i, 4'hf, rate_code_reg, low_dens};
  wire [7:0] diag_m30 = {disk_change_in_i, 3'h7, dma_enable_i, no_precomp_flag_reg,
                         rate_code_reg};
  wire [7:0] diag_at  = {~disk_change_in_i, 7'h00};

  // ---------------------------------------------------------------
  // interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  logic [3:0] int_stat_reg;
  logic [3:0] int_mask_reg;
  wire  [3:0] int_ev = {wr_rate && bus_i.wdata[FRS_PWRDN_BIT], res_push_i,
                        wr_rate || wr_cfg, swrst_reg};
  wire  [3:0] int_clr = wr_istat ? bus_i.wdata[3:0] : 4'h0;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      int_stat_reg <= 4'h0;
      int_mask_reg <= FRS_INT_MASK_RST;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clr) | int_ev;
      if (wr_imask) int_mask_reg <= bus_i.wdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] rd_val;
  logic [7:0] rd_oe;
  always_comb begin
    rd_val = 8'h00;
    rd_oe  = 8'hff;
    unique case (bus_i.addr)
      FRS_MAIN_STATUS_OFF: rd_val = main_status_i;
      FRS_CMD_DATA_OFF:    rd_val = res_avail ? res_mem[res_rd_reg] : 8'h00;
      FRS_DIAG_INPUT_OFF: begin
        unique case (mode_i)
          FRS_MODE_AT: begin
            rd_val = diag_at;
            rd_oe  = 8'h80;
          end
          FRS_MODE_STD: rd_val = diag_std;
          FRS_MODE_M30: rd_val = diag_m30;
          default:      rd_val = diag_std;
        endcase
      end
      FRS_INT_STATUS_OFF:  rd_val = {4'h0, int_stat_reg};
      FRS_INT_MASK_OFF:    rd_val = {4'h0, int_mask_reg};
      FRS_FIFO_CTRL_OFF:   rd_val = {3'h0, fifo_en_reg, fifo_thr_reg};
      default:             rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o       <= 8'h00;
      rdata_oe_o    <= 8'h00;
      cmd_wr_o      <= 1'b0;
      cmd_data_o    <= 8'h00;
      ctrl_o        <= '0;
      tape_2m_o     <= 1'b0;
      precomp_ps_o  <= 16'h0;
      fifo_en_o     <= 1'b0;
      fifo_thresh_o <= 4'h0;
      irq_o         <= 1'b0;
    end else begin
      rdata_o       <= bus_i.rd ? rd_val : 8'h00;
      rdata_oe_o    <= bus_i.rd ? rd_oe : 8'h00;
      cmd_wr_o      <= wr_data;
      cmd_data_o    <= wr_data ? bus_i.wdata : cmd_data_o;
      ctrl_o.rate_code             <= rate_code_reg;
      ctrl_o.precomp_delay_sel     <= precomp_sel;
      ctrl_o.reduced_write_current <= rwc_high;
      ctrl_o.fm_illegal            <= (rate_code_reg == FRS_RATE_1M);
      ctrl_o.power_down            <= rate_sel_reg[FRS_PWRDN_BIT];
      ctrl_o.soft_reset            <= swrst_reg;
      tape_2m_o     <= tape_2m;
      precomp_ps_o  <= precomp_ps[15:0];
      fifo_en_o     <= fifo_en_reg;
      fifo_thresh_o <= fifo_thr_reg;
      irq_o         <= |(int_stat_reg & int_mask_reg);
    end
  end
endmodule : frs_regs
`default_nettype wire

/* File: bench/frs_regs_checker.sv */
// port assertions for the floppy rate and status register bank
`timescale 1ns/100ps
`default_nettype none
module frs_regs_checker (
  input wire logic                  clk_i,            // clock
  input wire logic                  rst_b_i,          // sync reset, low
  input wire frs_pkg::frs_bus_req_t bus_i,            // register request
  input wire logic [7:0]            rdata_o,          // read data
  input wire logic [7:0]            rdata_oe_o,       // read drive enables
  input wire frs_pkg::frs_mode_t    mode_i,           // interface mode
  input wire logic                  disk_change_in_i, // disk change pin
  input wire logic                  dma_enable_i,     // dma enable level
  input wire logic                  cmd_wr_o,         // data port write
  input wire logic [7:0]            cmd_data_o,       // data port byte
  input wire frs_pkg::frs_ctrl_t    ctrl_o,           // rate controls
  input wire logic                  fifo_en_o         // fifo enabled
);
  import frs_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic wr4 = bus_i.wr && bus_i.addr == FRS_RATE_SELECT_OFF;
  wire logic wr7 = bus_i.wr && bus_i.addr == FRS_CONFIG_CTRL_OFF;
  wire logic rd7 = bus_i.rd && bus_i.addr == FRS_DIAG_INPUT_OFF;
  // controls lag the register by one stage, hence the extra cycle
  AST_RATE_LAST: assert property ((wr4 || wr7) |=> ##1
    ctrl_o.rate_code == $past(bus_i.wdata[1:0], 2)) else $error("rate code stale");
  AST_RWC: assert property ((wr4 || wr7) |=> ##1 ctrl_o.fm_illegal == (&$past(bus_i.wdata[1:0], 2))
    && ctrl_o.reduced_write_current == ~^$past(bus_i.wdata[1:0], 2)) else $error("rwc wrong");
  AST_PRECOMP: assert property (wr4 |=> ##1 ctrl_o.power_down == $past(bus_i.wdata[6], 2)
    && ctrl_o.precomp_delay_sel == $past(bus_i.wdata[4:2], 2)) else $error("precomp wrong");
  AST_SWRST: assert property (wr4 && bus_i.wdata[7] |=> ##1 ctrl_o.soft_reset)
    else $error("soft reset missing");
  AST_CMD_WR: assert property (bus_i.wr && bus_i.addr == FRS_CMD_DATA_OFF |=>
    cmd_wr_o && cmd_data_o == $past(bus_i.wdata)) else $error("data port byte lost");
  AST_RST: assert property ($rose(rst_b_i) |-> !fifo_en_o && ctrl_o == '0)
    else $error("reset state wrong");
  AST_DIAG_AT: assert property (rd7 && mode_i == FRS_MODE_AT |=> rdata_oe_o == 8'h80
    && rdata_o[7] == !$past(disk_change_in_i)) else $error("at diag wrong");
  AST_DIAG_STD: assert property (rd7 && mode_i == FRS_MODE_STD |=> rdata_o[0] == ^rdata_o[2:1]
    && rdata_o[7:3] == {!$past(disk_change_in_i), 4'hf}) else $error("std diag wrong");
  AST_DIAG_M30: assert property (rd7 && mode_i == FRS_MODE_M30 |=>
    rdata_o[7:3] == {$past(disk_change_in_i), 3'h7, $past(dma_enable_i)}) else $error("m30 diag wrong");
  cover property (wr4 && bus_i.wdata[7]);
  cover property (rd7 && mode_i == FRS_MODE_M30);
  cover property (wr7 ##2 rd7);
endmodule : frs_regs_checker
bind frs_regs frs_regs_checker u_frs_chk (.clk_i, .rst_b_i, .bus_i, .rdata_o, .rdata_oe_o,
  .mode_i, .disk_change_in_i, .dma_enable_i, .cmd_wr_o, .cmd_data_o, .ctrl_o, .fifo_en_o);
`default_nettype wire

/* File: bench/frs_host.sv */
// host processor model: single-cycle register reads and writes
`timescale 1ns/100ps
`default_nettype none
module frs_host (
  input  wire logic                 clk_i,   // bus clock
  input  wire logic [7:0]           rdata_i, // read data from the block
  output var frs_pkg::frs_bus_req_t bus_o    // request to the block
);
  import frs_pkg::*;
  initial bus_o = '0;
  // released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_o <= '{addr: ~a, wdata: bus_o.wdata, wr: 1'b0, rd: 1'b0};
    #1 d = rdata_i;
  endtask : rd
endmodule : frs_host
`default_nettype wire

/* File: bench/frs_regs_tb_top.sv */
// self-checking bench for the floppy rate and status register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module frs_regs_tb_top;
  import frs_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, dc = 1'b0, dma = 1'b0, push = 1'b0, cfg_cmd = 1'b0;
  logic cfg_en = 1'b0, cmd_wr, tape_2m, fifo_en, irq;
  logic [1:0] tape = 2'h0, term = 2'h0;
  logic [3:0] cfg_th = 4'h0, fifo_th;
  logic [7:0] rdat = 8'h00, ms = 8'h5a, rdata, rdata_oe, cmd_data;
  logic [15:0] precomp_ps;
  frs_mode_t mode = FRS_MODE_STD;
  frs_bus_req_t bus;
  frs_ctrl_t ctrl;
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #50 clk = ~clk;
  frs_host host (.clk_i(clk), .rdata_i(rdata), .bus_o(bus));
  frs_regs #(.CLK_PERIOD_PS(100000)) dut (.clk_i(clk), .rst_b_i(rst_b), .bus_i(bus),
    .rdata_o(rdata), .rdata_oe_o(rdata_oe), .mode_i(mode), .disk_change_in_i(dc),
    .dma_enable_i(dma), .main_status_i(ms), .tape_rate_i(tape), .res_push_i(push),
    .res_data_i(rdat), .res_term_i(term), .cfg_cmd_i(cfg_cmd), .cfg_fifo_en_i(cfg_en),
    .cfg_thresh_i(cfg_th), .cmd_wr_o(cmd_wr), .cmd_data_o(cmd_data), .ctrl_o(ctrl),
    .tape_2m_o(tape_2m), .precomp_ps_o(precomp_ps), .fifo_en_o(fifo_en),
    .fifo_thresh_o(fifo_th), .irq_o(irq));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic t_reset();
    logic [7:0] d;
    `CHK(ctrl, '0)
    `CHK(fifo_en, 1'b0)
    host.rd(FRS_DIAG_INPUT_OFF, d);
    `CHK(d, 8'hf8)
    host.rd(FRS_MAIN_STATUS_OFF, d);
    `CHK(d, 8'h5a)
    host.rd(FRS_RESULT_LOAD_OFF, d);
    `CHK(d, 8'h00)
  endtask : t_reset
  task automatic t_rate_diag();
    logic [7:0] d;
    logic [1:0] r;
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 4; i++) begin
        r = i[1:0];
        @(posedge clk);
        mode <= frs_mode_t'(m);
        dc <= r[0];
        dma <= r[1];
        host.wr(FRS_RATE_SELECT_OFF, {6'h00, ~r});
        host.wr(FRS_CONFIG_CTRL_OFF, {5'h00, m == 2 && r[0], r});
        step(2);
        `CHK(ctrl.rate_code, r)
        `CHK(ctrl.reduced_write_current, r[1] ~^ r[0])
        `CHK(ctrl.fm_illegal, &r)
        host.rd(FRS_DIAG_INPUT_OFF, d);
        if (m == 0) `CHK(d[7], ~r[0])
        else if (m == 1) `CHK(d, {~r[0], 4'hf, r, r[1] ^ r[0]})
        else `CHK(d, {r[0], 3'h7, r[1], r[0], r})
      end
    end
  endtask : t_rate_diag
  function automatic logic [15:0] exp_ps(input logic [1:0] r, input logic t2, input logic [2:0] c);
    if (c == FRS_PRECOMP_OFF) return 16'h0000;
    if (c != FRS_PRECOMP_DEFAULT) return 16'(int'(c) * (t2 ? FRS_DLY_STEP2M_PS : FRS_DLY_STEP_PS));
    if (t2) return 16'(FRS_DLY_DEF_2M_PS);
    return 16'(r == FRS_RATE_1M ? FRS_DLY_DEF_1M_PS : FRS_DLY_DEF_LOW_PS);
  endfunction : exp_ps
  task automatic t_precomp();
    logic [1:0] r;
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 8; c++) begin
        r = (k == 0) ? FRS_RATE_500K : (k == 1 ? FRS_RATE_1M : FRS_RATE_300K);
        @(posedge clk);
        tape <= (k == 2) ? 2'h2 : 2'h0;
        host.wr(FRS_RATE_SELECT_OFF, {3'h0, c[2:0], r});
        step(4);
        `CHK(ctrl.precomp_delay_sel, c[2:0])
        `CHK(tape_2m, k == 2)
        `CHK(precomp_ps, exp_ps(r, k == 2, c[2:0]))
      end
    end
  endtask : t_precomp
  task automatic t_results();
    logic [7:0] d;
    host.wr(FRS_CMD_DATA_OFF, 8'h4d);
    step(1);
    `CHK(cmd_wr, 1'b1)
    `CHK(cmd_data, 8'h4d)
    for (int t = 1; t < 4; t++) begin
      // five pushes: the fifth overflows the four-deep stack and is dropped
      for (int n = 0; n < 5; n++) begin
        @(posedge clk);
        push <= 1'b1;
        rdat <= 8'(8'h11 * (n + 1));
        term <= t[1:0];
      end
      @(posedge clk);
      push <= 1'b0;
      for (int n = 0; n < 5; n++) begin
        host.rd(FRS_CMD_DATA_OFF, d);
        `CHK(d, n == 4 ? 8'h00 : (n == 0 ? {t[1:0], 6'h11} : 8'(8'h11 * (n + 1))))
      end
    end
  endtask : t_results
  task automatic t_swrst_irq();
    logic [7:0] d;
    host.wr(FRS_INT_STATUS_OFF, 8'h0f);
    host.wr(FRS_INT_MASK_OFF, 8'h0f);
    @(posedge clk);
    cfg_cmd <= 1'b1;
    cfg_en <= 1'b1;
    cfg_th <= 4'h9;
    push <= 1'b1;
    @(posedge clk);
    cfg_cmd <= 1'b0;
    push <= 1'b0;
    step(2);
    `CHK(fifo_en, 1'b1)
    `CHK(fifo_th, 4'h9)
    `CHK(irq, 1'b1)
    host.rd(FRS_INT_STATUS_OFF, d);
    `CHK(d[3:0], 4'h4)
    host.wr(FRS_INT_STATUS_OFF, 8'h0f);
    host.wr(FRS_INT_MASK_OFF, 8'h00);
    host.wr(FRS_RATE_SELECT_OFF, 8'h80);
    step(3);
    `CHK(fifo_en, 1'b0)
    `CHK(irq, 1'b0)
    host.rd(FRS_CMD_DATA_OFF, d);
    `CHK(d, 8'h00)
    host.wr(FRS_INT_STATUS_OFF, 8'h0f);
    step(2);
    `CHK(irq, 1'b0)
    host.wr(FRS_RATE_SELECT_OFF, 8'h40);
    step(3);
    `CHK(ctrl.power_down, 1'b1)
    host.rd(FRS_INT_STATUS_OFF, d);
    `CHK(d[3:0], 4'ha)
    host.wr(FRS_INT_MASK_OFF, 8'h0f);
    step(2);
    `CHK(irq, 1'b1)
  endtask : t_swrst_irq
  initial begin
    step(6);
    rst_b <= 1'b1;
    t_reset();
    t_rate_diag();
    t_precomp();
    t_results();
    t_swrst_irq();
    complete_run();
  end
endmodule : frs_regs_tb_top
`default_nettype wire
